//--- slv10_bus_master.sv
// Behavioural two-wire bus master that sits on the far side of the slave.
`timescale 1ns/1ps
module slv10_bus_master
#(
	parameter int HALF = 20
)
(
	input wire logic clk_sys,
	input wire logic scl_bus,
	input wire logic sda_bus,
	output logic scl_rel,
	output logic sda_rel
);
	// Both lines start released; the pull-ups hold them high.
	initial
	begin
		scl_rel = 1'b1;
		sda_rel = 1'b1;
	end
	// Waits a number of system clock edges.
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
	endtask : tick
	// Releases the clock and waits while the slave stretches it, with a bound.
	task automatic rise();
		int n;
		n = 0;
		scl_rel <= 1'b1;
		@(posedge clk_sys);
		while (scl_bus !== 1'b1 && n < 20000)
		begin
			@(posedge clk_sys);
			n++;
		end
		tick(HALF);
	endtask : rise
	// Pulls the clock low, then waits so that data never moves with the edge.
	task automatic fall();
		scl_rel <= 1'b0;
		tick(4);
	endtask : fall
	// Start or repeated start: data falls while the clock is high.
	task automatic bus_start();
		sda_rel <= 1'b1;
		tick(HALF);
		rise();
		sda_rel <= 1'b0;
		tick(HALF);
		fall();
	endtask : bus_start
	// Stop: data rises while the clock is high.
	task automatic bus_stop();
		sda_rel <= 1'b0;
		tick(HALF);
		rise();
		sda_rel <= 1'b1;
		tick(HALF);
	endtask : bus_stop
	// Sends one byte most significant bit first and returns the ninth bit.
	task automatic put_byte(input logic [7:0] b, output logic ack);
		for (int i = 7; i >= 0; i--)
		begin
			sda_rel <= b[i];
			tick(HALF);
			rise();
			fall();
		end
		sda_rel <= 1'b1;
		tick(HALF);
		rise();
		ack = sda_bus;
		fall();
		// Lets the slave finish its acknowledge work before anyone looks at it.
		tick(HALF);
	endtask : put_byte
endmodule : slv10_bus_master

//--- slv10_params.svh
// Constants for the ten-bit addressed two-wire slave receive block.
`ifndef SLV10_PARAMS_SVH
`define SLV10_PARAMS_SVH
// --------------------------------------------------------------------
// Clock and bus timing
// --------------------------------------------------------------------
// System clock rate in MHz.
`define SYS_CLOCK_MHZ 20
// One bus clock period in ns.
`define BUS_CLOCK_PERIOD_NS 10000
// Least start hold time in system cycles, rounded up.
`define START_HOLD_CYCLES ((`BUS_CLOCK_PERIOD_NS * `SYS_CLOCK_MHZ + 999) / 1000)
// Width of the start hold timer.
`define TMR_W 16
// --------------------------------------------------------------------
// Byte framing
// --------------------------------------------------------------------
// Bit count value at the eighth clock pulse.
`define BIT_LAST 4'h7
// Bit count marking that the acknowledge pulse was seen.
`define ACK_PULSE 4'h9
// Byte counter value that selects the count-end answer.
`define CNT_ZERO 8'h00
// --------------------------------------------------------------------
// Event flag positions in irq_flag_register
// --------------------------------------------------------------------
`define FLAG_W 6
`define F_START 0
`define F_STOP 1
`define F_ADDR 2
`define F_WRITE 3
`define F_COUNT 4
`define F_NACK 5
`endif

//--- slv10_pkg.sv
// Types shared by the ten-bit addressed two-wire slave receive block.
`include "slv10_params.svh"
package slv10_pkg;
	// Sequencer states, slave path first, then master start path.
	typedef enum logic [3:0]
	{
		st_idle = 4'b0000,
		st_haddr = 4'b0001,
		st_hack = 4'b0010,
		st_laddr = 4'b0011,
		st_lack = 4'b0100,
		st_data = 4'b0101,
		st_dack = 4'b0110,
		st_mwait = 4'b0111,
		st_msda = 4'b1000,
		st_mheld = 4'b1001
	} state_t;

	// All state kept on the system clock.
	typedef struct packed
	{
		state_t state;
		logic scl_s1;
		logic scl_s2;
		logic sda_s1;
		logic sda_s2;
		logic prev_scl;
		logic prev_sda;
		logic [7:0] sh;
		logic [3:0] cnt;
		logic driven;
		logic nack;
		logic rw;
		logic data_addr;
		logic stretch;
		logic rx_wait;
		logic rx_full;
		logic [7:0] rx_buffer;
		logic [7:0] lo_buf;
		logic [7:0] hi_buf;
		logic [7:0] byte_counter;
		logic [`FLAG_W-1:0] flags;
		logic gen_irq;
		logic slave_active;
		logic bus_free;
		logic sda_hold;
		logic scl_hold;
		logic scl_mst;
		logic [`TMR_W-1:0] tmr;
	} sys_t;

	// All state kept on the link clock.
	typedef struct packed
	{
		logic scl_m;
		logic scl_smp;
		logic sda_m;
		logic sda_smp;
		logic sh1;
		logic sh2;
		logic dh1;
		logic dh2;
	} link_t;
endpackage : slv10_pkg

//--- slv10_receive.sv
// Ten-bit addressed two-wire slave receive path with master start generation.
`timescale 1ns/1ps
`include "slv10_params.svh"

// Behaviour
// - High byte compared against both high addresses.
// - All seven high bits compared, prefix unchecked.
// - Low byte compared against both low addresses.
// - Slave active only after both bytes match.
// - Start sets flag, optionally general interrupt.
// - High match stores byte; mismatch goes idle.
// - Address hold stretches clock, drives ack value.
// - Pending error forces high address NACK, then idle.
// - Low match sets active, match flag, buffer.
// - Ack hold stretches after low address and data acknowledges.
// - Stop sets stop flag, returns idle.
// - Full receive buffer stretches until read.
// - Eighth pulse loads buffer, sets write flags.
// - Write hold stretches after data load.
// - Counter zero selects count-end ack, else decrement.
// - Counter zero after ack sets count-done.
// - NACK answer sets flag, returns idle.
// - Buffer read clears full flag.
// - Start triggered by start bit or transmit write.
// - Master waits bus free, then pulls data low.
// - Clock pulled low one bus period later.
module slv10_receive
#(
	parameter int unsigned START_HOLD = `START_HOLD_CYCLES
)
(
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic link_clk,
	input wire logic scl_in,
	output logic scl_out,
	output logic scl_oe_n,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_n,
	input wire logic [6:0] high_address_a,
	input wire logic [6:0] high_address_b,
	input wire logic [7:0] low_address_a,
	input wire logic [7:0] low_address_b,
	input wire logic start_irq_enable,
	input wire logic address_hold_enable,
	input wire logic ack_hold_enable,
	input wire logic write_hold_enable,
	input wire logic ack_value,
	input wire logic count_end_ack_value,
	input wire logic error_pending,
	input wire logic stretch_release,
	input wire logic rx_read,
	input wire logic [`FLAG_W-1:0] flag_clear,
	input wire logic irq_clear,
	input wire logic count_load,
	input wire logic [7:0] count_value,
	input wire logic start_write,
	input wire logic tx_write,
	input wire logic auto_start_disable,
	input wire logic master_release,
	output logic [`FLAG_W-1:0] irq_flag_register,
	output logic general_irq_flag,
	output logic clock_stretch_bit,
	output logic slave_active_flag,
	output logic rx_full_flag,
	output logic [7:0] rx_buffer,
	output logic [7:0] low_address_buffer,
	output logic [7:0] high_address_buffer,
	output logic [7:0] byte_counter,
	output logic read_write,
	output logic data_not_address,
	output logic bus_free_flag
);
	// ----------------------------------------------------------------
	// Elaboration checks
	// ----------------------------------------------------------------
	// The timer cannot count a hold longer than its width allows.
	if (START_HOLD < 1 || START_HOLD > 65535)
	begin : bad_start_hold
		$error("START_HOLD out of range");
	end

	// ----------------------------------------------------------------
	// State and helpers
	// ----------------------------------------------------------------
	slv10_pkg::sys_t r; // Registered system-side state.
	slv10_pkg::sys_t n; // Next system-side state.
	slv10_pkg::link_t lk; // Registered link-side state.
	slv10_pkg::link_t ln; // Next link-side state.
	logic rise; // Bus clock rising edge seen.
	logic fall; // Bus clock falling edge seen.
	logic st_ev; // Start or repeated start seen.
	logic sp_ev; // Stop seen.
	logic master; // Sequencer owns the bus as master.
	logic ack_st; // Sequencer is in an acknowledge phase.
	logic drive_ack; // Acknowledge bit goes onto the data line now.
	logic ack_sel; // Acknowledge bit value, high means NACK.
	logic [7:0] nxt_sh; // Shift register with the new bit.
	logic want_scl; // Some cause asks to hold the clock low.

	// Match a received byte against either of two addresses.
	function automatic logic hit(input logic [7:0] v, input logic [7:0] a, input logic [7:0] b);
		hit = (v == a) || (v == b);
	endfunction : hit

	// ----------------------------------------------------------------
	// Bus event decode
	// ----------------------------------------------------------------
	// Edges come from the synchronised copies only, never the first flop.
	assign rise = r.scl_s2 & ~r.prev_scl;
	assign fall = ~r.scl_s2 & r.prev_scl;
	assign st_ev = r.scl_s2 & r.prev_scl & r.prev_sda & ~r.sda_s2;
	assign sp_ev = r.scl_s2 & r.prev_scl & ~r.prev_sda & r.sda_s2;
	assign master = (r.state == slv10_pkg::st_mwait) || (r.state == slv10_pkg::st_msda)
		|| (r.state == slv10_pkg::st_mheld);
	assign ack_st = (r.state == slv10_pkg::st_hack) || (r.state == slv10_pkg::st_lack)
		|| (r.state == slv10_pkg::st_dack);
	// The bit is placed only while the clock is low and nobody stretches.
	assign drive_ack = ack_st & ~r.driven & ~r.stretch & ~r.scl_s2;
	assign nxt_sh = {r.sh[6:0], r.sda_s2};
	// A pending error overrides the software answer on the high address byte.
	always_comb
	begin
		if (r.state == slv10_pkg::st_hack)
			ack_sel = error_pending | ack_value;
		else if (r.state == slv10_pkg::st_dack && r.byte_counter == `CNT_ZERO)
			ack_sel = count_end_ack_value;
		else
			ack_sel = ack_value;
	end
	// Clock is also held until the acknowledge bit is on the line.
	assign want_scl = r.stretch | r.rx_wait | (ack_st & ~r.driven);

	// ----------------------------------------------------------------
	// System-side sequencer
	// ----------------------------------------------------------------
	// Clears are applied first so that a same-cycle event set wins.
	always_comb
	begin
		n = r;
		n.scl_s1 = lk.scl_smp;
		n.scl_s2 = r.scl_s1;
		n.sda_s1 = lk.sda_smp;
		n.sda_s2 = r.sda_s1;
		n.prev_scl = r.scl_s2;
		n.prev_sda = r.sda_s2;
		n.stretch = r.stretch & ~stretch_release;
		n.rx_full = r.rx_full & ~rx_read;
		n.flags = r.flags & ~flag_clear;
		n.gen_irq = r.gen_irq & ~irq_clear;
		n.rx_wait = r.rx_wait & n.rx_full;
		if (count_load)
			n.byte_counter = count_value;
		if (st_ev)
		begin
			// Any start restarts address reception unless we are the master.
			n.flags[`F_START] = 1'b1;
			if (start_irq_enable)
				n.gen_irq = 1'b1;
			if (!master)
			begin
				n.state = slv10_pkg::st_haddr;
				n.cnt = 4'h0;
				n.driven = 1'b0;
				n.sda_hold = 1'b0;
			end
		end
		else if (sp_ev && !master)
		begin
			// Stop ends everything, the slave goes quiet.
			n.flags[`F_STOP] = 1'b1;
			n.state = slv10_pkg::st_idle;
			n.slave_active = 1'b0;
			n.sda_hold = 1'b0;
			n.rx_wait = 1'b0;
		end
		else
		begin
			unique case (r.state)
				slv10_pkg::st_idle:
				begin
					// Start request source chosen by the auto-start setting.
					if (auto_start_disable ? start_write : tx_write)
						n.state = slv10_pkg::st_mwait;
				end
				slv10_pkg::st_haddr, slv10_pkg::st_laddr, slv10_pkg::st_data:
				begin
					// Hold before the eighth pulse if the last byte is unread.
					if (fall && r.state == slv10_pkg::st_data && r.cnt == `BIT_LAST && r.rx_full)
						n.rx_wait = 1'b1;
					if (rise)
					begin
						n.sh = nxt_sh;
						n.cnt = r.cnt + 4'h1;
						if (r.cnt == `BIT_LAST)
						begin
							n.cnt = 4'h0;
							n.driven = 1'b0;
							n.state = slv10_pkg::st_idle;
							if (r.state == slv10_pkg::st_haddr)
							begin
								// Bit zero of the high byte is the direction bit.
								if (hit({nxt_sh[7:1], 1'b0}, {high_address_a, 1'b0}, {high_address_b, 1'b0}))
								begin
									n.rw = nxt_sh[0];
									n.data_addr = 1'b0;
									n.hi_buf = nxt_sh;
									n.state = slv10_pkg::st_hack;
									if (address_hold_enable)
									begin
										n.stretch = 1'b1;
										n.gen_irq = 1'b1;
									end
								end
							end
							else if (r.state == slv10_pkg::st_laddr)
							begin
								if (hit(nxt_sh, low_address_a, low_address_b))
								begin
									n.slave_active = 1'b1;
									n.flags[`F_ADDR] = 1'b1;
									n.data_addr = 1'b0;
									n.lo_buf = nxt_sh;
									n.state = slv10_pkg::st_lack;
									if (address_hold_enable)
									begin
										n.stretch = 1'b1;
										n.gen_irq = 1'b1;
									end
								end
							end
							else
							begin
								// Data byte lands in the receive buffer.
								n.data_addr = 1'b1;
								n.flags[`F_WRITE] = 1'b1;
								n.rx_buffer = nxt_sh;
								n.rx_full = 1'b1;
								n.state = slv10_pkg::st_dack;
								if (write_hold_enable)
								begin
									n.stretch = 1'b1;
									n.gen_irq = 1'b1;
								end
							end
						end
					end
				end
				slv10_pkg::st_hack, slv10_pkg::st_lack, slv10_pkg::st_dack:
				begin
					if (drive_ack)
					begin
						// Answer is sampled only now, after software had its say.
						n.driven = 1'b1;
						n.nack = ack_sel;
						n.sda_hold = ~ack_sel;
						if (r.state == slv10_pkg::st_dack && r.byte_counter != `CNT_ZERO)
							n.byte_counter = r.byte_counter - 8'h01;
					end
					else if (rise && r.driven)
						n.cnt = `ACK_PULSE;
					else if (fall && r.cnt == `ACK_PULSE)
					begin
						// The acknowledge pulse is over.
						n.sda_hold = 1'b0;
						n.cnt = 4'h0;
						n.driven = 1'b0;
						if (r.state == slv10_pkg::st_dack && r.byte_counter == `CNT_ZERO)
							n.flags[`F_COUNT] = 1'b1;
						if (r.nack)
						begin
							n.flags[`F_NACK] = 1'b1;
							n.state = slv10_pkg::st_idle;
						end
						else
						begin
							if (ack_hold_enable && r.state != slv10_pkg::st_hack)
							begin
								n.stretch = 1'b1;
								n.gen_irq = 1'b1;
							end
							// A read request is out of this path's scope.
							if (r.state == slv10_pkg::st_hack)
								n.state = r.rw ? slv10_pkg::st_idle : slv10_pkg::st_laddr;
							else
								n.state = slv10_pkg::st_data;
						end
					end
				end
				slv10_pkg::st_mwait:
				begin
					if (r.bus_free)
					begin
						n.sda_hold = 1'b1;
						n.flags[`F_START] = 1'b1;
						n.tmr = '0;
						n.state = slv10_pkg::st_msda;
					end
				end
				slv10_pkg::st_msda:
				begin
					if (r.tmr == `TMR_W'(START_HOLD - 1))
					begin
						n.scl_mst = 1'b1;
						n.state = slv10_pkg::st_mheld;
					end
					else
						n.tmr = r.tmr + `TMR_W'(1);
				end
				slv10_pkg::st_mheld:
				begin
					// Both lines stay low until the byte sender takes over.
					if (master_release)
					begin
						n.scl_mst = 1'b0;
						n.sda_hold = 1'b0;
						n.state = slv10_pkg::st_idle;
					end
				end
				default:
					n.state = slv10_pkg::st_idle;
			endcase
		end
		// Slave holds grab the clock only once it is already low; the master start pulls it at once.
		n.scl_hold = n.scl_mst | (want_scl & (~r.scl_s2 | r.scl_hold));
		// A waiting master request still sees a free bus, or its own wait could never end.
		n.bus_free = ((n.state == slv10_pkg::st_idle) | (n.state == slv10_pkg::st_mwait))
			& r.scl_s2 & r.sda_s2;
	end

	// System-side register.
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
			r <= '0;
		else
			r <= n;
	end

	// ----------------------------------------------------------------
	// Link-side pin logic
	// ----------------------------------------------------------------
	// Pins are sampled twice here and the holds cross in by two flops.
	always_comb
	begin
		ln = lk;
		ln.scl_m = scl_in;
		ln.scl_smp = lk.scl_m;
		ln.sda_m = sda_in;
		ln.sda_smp = lk.sda_m;
		ln.sh1 = r.scl_hold;
		ln.sh2 = lk.sh1;
		ln.dh1 = r.sda_hold;
		ln.dh2 = lk.dh1;
	end

	// Link-side register, released lines after reset.
	always_ff @(posedge link_clk or negedge reset_n)
	begin
		if (!reset_n)
			lk <= '0;
		else
			lk <= ln;
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign scl_out = 1'b0;
	assign sda_out = 1'b0;
	assign scl_oe_n = ~lk.sh2;
	assign sda_oe_n = ~lk.dh2;
	assign irq_flag_register = r.flags;
	assign general_irq_flag = r.gen_irq;
	assign clock_stretch_bit = r.stretch;
	assign slave_active_flag = r.slave_active;
	assign rx_full_flag = r.rx_full;
	assign rx_buffer = r.rx_buffer;
	assign low_address_buffer = r.lo_buf;
	assign high_address_buffer = r.hi_buf;
	assign byte_counter = r.byte_counter;
	assign read_write = r.rw;
	assign data_not_address = r.data_addr;
	assign bus_free_flag = r.bus_free;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (!reset_n);

	start_flag_a: assert property (st_ev |=> r.flags[`F_START]) else $error("start flag missed");
	start_irq_a: assert property (st_ev && start_irq_enable |=> r.gen_irq) else $error("start irq missed");
	stop_idle_a: assert property (sp_ev && !master |=> r.state == slv10_pkg::st_idle && r.flags[`F_STOP])
		else $error("stop not handled");
	active_a: assert property ($rose(r.slave_active) |-> $past(r.state) == slv10_pkg::st_laddr)
		else $error("active without low match");
	rx_load_a: assert property (r.state == slv10_pkg::st_data && rise && r.cnt == `BIT_LAST && !st_ev && !sp_ev
		|=> r.rx_full && r.data_addr && r.flags[`F_WRITE]) else $error("data byte not loaded");
	rx_clear_a: assert property (rx_read && r.state != slv10_pkg::st_data |=> !r.rx_full)
		else $error("read did not clear full");
	rx_wait_a: assert property (r.rx_wait && !r.scl_s2 |=> r.scl_hold) else $error("full buffer not held");
	count_ack_a: assert property (drive_ack && r.state == slv10_pkg::st_dack && r.byte_counter == `CNT_ZERO
		|=> r.nack == $past(count_end_ack_value) && r.sda_hold == !r.nack) else $error("count-end ack wrong");
	err_nack_a: assert property (drive_ack && r.state == slv10_pkg::st_hack && error_pending |=> r.nack && !r.sda_hold)
		else $error("error did not force nack");
	bus_wait_a: assert property (r.state == slv10_pkg::st_mwait && !r.bus_free |=> !r.sda_hold)
		else $error("start before bus free");
	scl_low_a: assert property (r.state == slv10_pkg::st_msda && r.tmr == `TMR_W'(START_HOLD - 1)
		|=> r.scl_hold ##1 r.scl_hold) else $error("clock not pulled after hold");
	flag_keep_a: assert property (r.flags[`F_NACK] && !flag_clear[`F_NACK] |=> r.flags[`F_NACK])
		else $error("flag dropped");

	data_ack_c: cover property (r.state == slv10_pkg::st_dack ##1 r.state == slv10_pkg::st_data);
	count_done_c: cover property ($rose(r.flags[`F_COUNT]));
	master_held_c: cover property (r.state == slv10_pkg::st_mheld);
	rx_stall_c: cover property ($rose(r.rx_wait));
endmodule : slv10_receive

//--- slv10_receive_test.sv
// Self-checking testbench for the ten-bit addressed slave receive block.
`timescale 1ns/1ps
`include "slv10_params.svh"
module slv10_receive_test;
	// --------------------------------------------------------------
	// Signals
	// --------------------------------------------------------------
	localparam int HOLD = 20;
	logic clk_sys = 1'b0, link_clk = 1'b0, reset_n = 1'b0;
	logic [6:0] high_address_a = 7'h7A, high_address_b = 7'h03;
	logic [7:0] low_address_a = 8'hA5, low_address_b = 8'h5A, count_value = 8'h01;
	logic start_irq_enable = 1'b1, address_hold_enable = 1'b0, ack_hold_enable = 1'b0;
	logic write_hold_enable = 1'b0, ack_value = 1'b0, count_end_ack_value = 1'b1;
	logic error_pending = 1'b0, stretch_release = 1'b0, rx_read = 1'b0, irq_clear = 1'b0;
	logic [`FLAG_W-1:0] flag_clear = 6'h00;
	logic count_load = 1'b0, start_write = 1'b0, tx_write = 1'b0;
	logic auto_start_disable = 1'b1, master_release = 1'b0;
	logic scl_out, scl_oe_n, sda_out, sda_oe_n, scl_rel, sda_rel;
	logic [`FLAG_W-1:0] irq_flag_register;
	logic general_irq_flag, clock_stretch_bit, slave_active_flag, rx_full_flag;
	logic [7:0] rx_buffer, low_address_buffer, high_address_buffer, byte_counter;
	logic read_write, data_not_address, bus_free_flag;
	int n_errors = 0;
	int comparisons = 0;
	// The wire is low while any party pulls it; the pull-up lifts it otherwise.
	wire scl_bus;
	wire sda_bus;
	assign scl_bus = scl_rel & (scl_oe_n | scl_out);
	assign sda_bus = sda_rel & (sda_oe_n | sda_out);
	// Free-running clocks with unrelated periods.
	always #25 clk_sys = ~clk_sys;
	always #15 link_clk = ~link_clk;
	slv10_receive #(.START_HOLD(HOLD)) i_dut (.clk_sys, .reset_n, .link_clk, .scl_in(scl_bus), .scl_out,
		.scl_oe_n, .sda_in(sda_bus), .sda_out, .sda_oe_n, .high_address_a, .high_address_b, .low_address_a,
		.low_address_b, .start_irq_enable, .address_hold_enable, .ack_hold_enable, .write_hold_enable,
		.ack_value, .count_end_ack_value, .error_pending, .stretch_release, .rx_read, .flag_clear,
		.irq_clear, .count_load, .count_value, .start_write, .tx_write, .auto_start_disable,
		.master_release, .irq_flag_register, .general_irq_flag, .clock_stretch_bit, .slave_active_flag,
		.rx_full_flag, .rx_buffer, .low_address_buffer, .high_address_buffer, .byte_counter, .read_write,
		.data_not_address, .bus_free_flag);
	slv10_bus_master #(.HALF(20)) i_master (.clk_sys, .scl_bus, .sda_bus, .scl_rel, .sda_rel);
	// --------------------------------------------------------------
	// Helpers
	// --------------------------------------------------------------
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
	endtask : cyc
	// Compares a value and counts the result.
	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
		comparisons++;
		if (got !== exp)
		begin
			n_errors++;
			$display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
		end
	endtask : chk
	task automatic done(input string s);
		$display("test %s finished", s);
	endtask : done
	// Clears every event flag and the general interrupt in one pulse.
	task automatic clr();
		flag_clear <= 6'h3F;
		irq_clear <= 1'b1;
		cyc(1);
		flag_clear <= 6'h00;
		irq_clear <= 1'b0;
		cyc(1);
	endtask : clr
	task automatic read_rx();
		rx_read <= 1'b1;
		cyc(1);
		rx_read <= 1'b0;
		cyc(1);
	endtask : read_rx
	// Software side of a hold: waits for the stretch, answers, releases.
	task automatic serve(input logic nak);
		int n;
		n = 0;
		// The hold only counts once the clock is really pulled low.
		while ((clock_stretch_bit !== 1'b1 || scl_oe_n !== 1'b0) && n < 2000)
		begin
			cyc(1);
			n++;
		end
		chk(8'(clock_stretch_bit), 8'h01, "stretch bit");
		chk(8'(scl_oe_n), 8'h00, "clock held");
		chk(8'(general_irq_flag), 8'h01, "hold irq");
		ack_value <= nak;
		irq_clear <= 1'b1;
		stretch_release <= 1'b1;
		cyc(1);
		irq_clear <= 1'b0;
		stretch_release <= 1'b0;
		// One more edge, so that a following call never sees the old stretch bit.
		cyc(1);
	endtask : serve
	// --------------------------------------------------------------
	// Scenarios
	// --------------------------------------------------------------
	task automatic t_reset();
		chk(8'(scl_oe_n), 8'h01, "scl released");
		chk(8'(sda_oe_n), 8'h01, "sda released");
		chk(8'(irq_flag_register), 8'h00, "flags at reset");
		cyc(12);
		chk(8'(bus_free_flag), 8'h01, "bus free");
		done("reset");
	endtask : t_reset
	// Full write: addresses, one acked byte, one byte that meets a full buffer and a zero count.
	task automatic t_write();
		logic a;
		count_load <= 1'b1;
		cyc(1);
		count_load <= 1'b0;
		i_master.bus_start();
		chk(8'(irq_flag_register[`F_START]), 8'h01, "start flag");
		chk(8'(general_irq_flag), 8'h01, "start irq");
		i_master.put_byte(8'hF4, a);
		chk(8'(a), 8'h00, "high ack");
		chk(high_address_buffer, 8'hF4, "high buffer");
		chk({read_write, data_not_address, slave_active_flag}, 8'h00, "after high");
		i_master.put_byte(8'h5A, a);
		chk(8'(a), 8'h00, "low ack");
		chk(low_address_buffer, 8'h5A, "low buffer");
		chk({slave_active_flag, irq_flag_register[`F_ADDR]}, 8'h03, "active and match");
		i_master.put_byte(8'h3C, a);
		chk(8'(a), 8'h00, "data ack");
		chk(rx_buffer, 8'h3C, "rx data");
		chk({rx_full_flag, irq_flag_register[`F_WRITE], data_not_address}, 8'h07, "load flags");
		chk(byte_counter, 8'h00, "count decremented");
		fork
			i_master.put_byte(8'hC3, a);
			begin
				cyc(450);
				chk(8'(scl_oe_n), 8'h00, "full buffer stretch");
				chk(rx_buffer, 8'h3C, "buffer kept");
				read_rx();
				chk(8'(rx_full_flag), 8'h00, "read clears full");
			end
		join
		chk(8'(a), 8'h01, "count end answer");
		chk(rx_buffer, 8'hC3, "second data");
		chk(8'(irq_flag_register[`F_COUNT]), 8'h01, "count done");
		chk(8'(irq_flag_register[`F_NACK]), 8'h01, "not acked");
		i_master.bus_stop();
		cyc(40);
		chk(8'(irq_flag_register[`F_STOP]), 8'h01, "stop flag");
		chk(8'(irq_flag_register[`F_COUNT]), 8'h01, "flag sticky");
		read_rx();
		clr();
		chk({irq_flag_register, general_irq_flag}, 8'h00, "flags cleared");
		done("write");
	endtask : t_write
	// Prefix not enforced, mismatches refused, pending error forces a refusal.
	task automatic t_mismatch();
		logic a;
		i_master.bus_start();
		i_master.put_byte(8'h06, a);
		chk(8'(a), 8'h00, "odd prefix matches");
		i_master.put_byte(8'h11, a);
		chk(8'(a), 8'h01, "low mismatch");
		chk(8'(slave_active_flag), 8'h00, "not active");
		i_master.bus_stop();
		i_master.bus_start();
		i_master.put_byte(8'hF6, a);
		chk(8'(a), 8'h01, "high mismatch");
		i_master.bus_stop();
		error_pending <= 1'b1;
		i_master.bus_start();
		i_master.put_byte(8'hF4, a);
		chk(8'(a), 8'h01, "error forces nack");
		i_master.bus_stop();
		error_pending <= 1'b0;
		clr();
		done("mismatch");
	endtask : t_mismatch
	// Address and data holds; software picks the data answer during the hold.
	task automatic t_hold();
		logic a;
		start_irq_enable <= 1'b0;
		address_hold_enable <= 1'b1;
		write_hold_enable <= 1'b1;
		ack_hold_enable <= 1'b1;
		count_value <= 8'h05;
		count_load <= 1'b1;
		cyc(1);
		count_load <= 1'b0;
		i_master.bus_start();
		fork
			i_master.put_byte(8'hF4, a);
			serve(1'b0);
		join
		chk(8'(a), 8'h00, "held high ack");
		fork
			i_master.put_byte(8'hA5, a);
			serve(1'b0);
		join
		chk(8'(a), 8'h00, "held low ack");
		serve(1'b0);
		fork
			i_master.put_byte(8'h81, a);
			serve(1'b1);
		join
		chk(8'(a), 8'h01, "software nack");
		chk(byte_counter, 8'h04, "count four");
		i_master.bus_stop();
		address_hold_enable <= 1'b0;
		write_hold_enable <= 1'b0;
		ack_hold_enable <= 1'b0;
		ack_value <= 1'b0;
		read_rx();
		clr();
		done("hold");
	endtask : t_hold
	// Master start from either trigger, with the clock falling HOLD cycles later.
	task automatic t_master();
		int n;
		tx_write <= 1'b1;
		cyc(1);
		tx_write <= 1'b0;
		cyc(30);
		chk(8'(sda_oe_n), 8'h01, "tx write ignored");
		start_write <= 1'b1;
		cyc(1);
		start_write <= 1'b0;
		n = 0;
		while (sda_oe_n !== 1'b0 && n < 100)
		begin
			cyc(1);
			n++;
		end
		chk({sda_oe_n, scl_oe_n}, 8'h01, "data low clock high");
		n = 0;
		while (scl_oe_n !== 1'b0 && n < 100)
		begin
			cyc(1);
			n++;
		end
		chk(8'(n >= HOLD - 1 && n <= HOLD + 3), 8'h01, "start hold time");
		chk(8'(irq_flag_register[`F_START]), 8'h01, "master start flag");
		master_release <= 1'b1;
		auto_start_disable <= 1'b0;
		cyc(1);
		master_release <= 1'b0;
		cyc(20);
		tx_write <= 1'b1;
		cyc(1);
		tx_write <= 1'b0;
		cyc(20);
		chk(8'(sda_oe_n), 8'h00, "tx write starts");
		master_release <= 1'b1;
		cyc(1);
		master_release <= 1'b0;
		done("master");
	endtask : t_master
	// --------------------------------------------------------------
	// Run control
	// --------------------------------------------------------------
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : stop_test
	initial
	begin
		cyc(6);
		reset_n <= 1'b1;
		t_reset();
		t_write();
		t_mismatch();
		t_hold();
		t_master();
		stop_test();
	end
	// The tests need about 6000 cycles; this bound cuts a hang short.
	initial
	begin
		#2000000;
		n_errors++;
		$display("[ERR] %0t watchdog expired", $time);
		stop_test();
	end
endmodule : slv10_receive_test
